//--- logic/dcip_pkg.sv
package dcip_pkg;

	// Completion code space and register geometry
	localparam int unsigned CODE_W      = 6;
	localparam int unsigned NUM_CODES   = 64;
	localparam int unsigned REG_W       = 32;
	localparam int unsigned OPTIONS_W   = 32;

	// Layout of the channel options word
	localparam int unsigned OPT_CODE_LSB     = 0;
	localparam int unsigned OPT_FINAL_BIT    = 8;
	localparam int unsigned OPT_INTERMED_BIT = 9;

	// Reset values of enable and pending registers
	localparam logic [REG_W-1:0] ENABLE_RESET  = 32'h0000_0000;
	localparam logic [REG_W-1:0] PENDING_RESET = 32'h0000_0000;

	// Completion code carried by an options word
	function automatic logic [CODE_W-1:0] dcip_code_of(input logic [OPTIONS_W-1:0] options);
		dcip_code_of = options[OPT_CODE_LSB +: CODE_W];
	endfunction : dcip_code_of

	// A code is returned only when the matching interrupt flag is set
	function automatic logic dcip_code_wanted(input logic [OPTIONS_W-1:0] options,
		input logic intermediate);
		dcip_code_wanted = intermediate ? options[OPT_INTERMED_BIT] : options[OPT_FINAL_BIT];
	endfunction : dcip_code_wanted

endpackage : dcip_pkg

//--- logic/dcip_if.sv
interface dcip_if;
	import dcip_pkg::*;

	logic              cmpl_valid;
	logic [CODE_W-1:0] cmpl_code;

	// Transfer engine drives codes, channel engine takes them
	modport transfer_end (output cmpl_valid, output cmpl_code);
	modport channel_end  (input  cmpl_valid, input  cmpl_code);

endinterface : dcip_if

//--- logic/dcip_transfer_end.sv
module dcip_transfer_end
	import dcip_pkg::*;
(
	input  wire logic                 CLK_I,
	input  wire logic                 RST_I,
	input  wire logic                 DONE_I,
	input  wire logic                 DONE_INTERMEDIATE_I,
	input  wire logic [OPTIONS_W-1:0] OPTIONS_I,
	output logic                      CODE_SENT_O,
	dcip_if.transfer_end              lnk
);

	logic              valid_r;
	logic [CODE_W-1:0] code_r;
	logic              hit;

	// Only flagged completions produce a code
	assign hit = DONE_I && dcip_code_wanted(OPTIONS_I, DONE_INTERMEDIATE_I);

	// One-cycle code pulse per normal completion
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			valid_r <= 1'b0;
		end else begin
			valid_r <= hit;
		end
	end

	// Code taken straight from the options word
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			code_r <= '0;
		end else if (hit) begin
			code_r <= dcip_code_of(OPTIONS_I);
		end
	end

	assign lnk.cmpl_valid = valid_r;
	assign lnk.cmpl_code  = code_r;
	assign CODE_SENT_O    = valid_r;

endmodule : dcip_transfer_end

//--- logic/dcip_channel_end.sv

// Timing, link side
// Transfer end: code one cycle after its completion
// Link code: pending bit one edge after the valid pulse
// Early code: pending bit one edge after the early strobe
// So an early code lands one cycle sooner than a normal one
// Back-to-back codes every cycle are taken, none dropped
// Repeat of a code already pending: pending bit and interrupt unchanged, seen pulse and last code still update
// Timing, register side
// Strobes act at the edge that samples them
// Enable, pending and interrupt all move at that same edge
// Readers see the new value from the next cycle on
// Several strobes in one cycle all apply together
// Zeros in the write data never touch a bit
// Interrupt
// A level, not a pulse, taken straight from a flop
// Rises only for a code both pending and enabled
// Pending bits set whether or not the code is enabled,
// so enabling later raises the interrupt at once
// Falls only once every enabled pending bit is cleared
// Hazards and trade-offs
// Set beats clear in one cycle: a code arriving while
// software clears its bit is kept, never silently lost
// Cost: software must read back after a clear to be sure
// Link and early code together: both bits set
// Only the link code is shown as the last code then
// Limitations
// No enable-clear path: only reset takes an enable away
// No way to ask for a fresh pulse while bits stay pending
// Enable and pending views only; no address decode here
// Code width and code count fixed by the package
module dcip_channel_end
	import dcip_pkg::*;
#(
	parameter int unsigned CODES_P  = NUM_CODES,
	parameter int unsigned HALF_W_P = REG_W
)
(
	input  wire logic                 CLK_I,
	input  wire logic                 RST_I,
	input  wire logic [REG_W-1:0]     WR_DATA_I,
	input  wire logic                 ENA_SET_LO_WR_I,
	input  wire logic                 ENA_SET_HI_WR_I,
	input  wire logic                 PEND_CLR_LO_WR_I,
	input  wire logic                 PEND_CLR_HI_WR_I,
	input  wire logic                 EARLY_DONE_I,
	input  wire logic                 EARLY_INTERMEDIATE_I,
	input  wire logic [OPTIONS_W-1:0] EARLY_OPTIONS_I,
	dcip_if.channel_end               lnk,
	output logic      [REG_W-1:0]     ENABLE_LO_O,
	output logic      [REG_W-1:0]     ENABLE_HI_O,
	output logic      [REG_W-1:0]     PENDING_LO_O,
	output logic      [REG_W-1:0]     PENDING_HI_O,
	output logic                      IRQ_O,
	output logic                      CODE_SEEN_O,
	output logic      [CODE_W-1:0]    LAST_CODE_O
);

	// Enable and pending state, whole code space in one vector
	logic [NUM_CODES-1:0] enable_r;
	logic [NUM_CODES-1:0] enable_nxt;
	logic [NUM_CODES-1:0] pending_r;
	logic [NUM_CODES-1:0] pending_nxt;
	logic                 irq_r;
	logic                 irq_nxt;
	logic                 seen_r;
	logic [CODE_W-1:0]    last_code_r;

	// Decoded write and event vectors
	logic [NUM_CODES-1:0] enable_set;
	logic [NUM_CODES-1:0] pending_clr;
	logic [NUM_CODES-1:0] link_set;
	logic [NUM_CODES-1:0] early_set;
	logic [NUM_CODES-1:0] code_set;
	logic                 early_hit;
	logic [CODE_W-1:0]    early_code;

	// Only two equal halves covering every code are served, since the
	// strobes and read-back ports are one register wide each
	if (HALF_W_P != REG_W) begin : g_bad_half
		$error("half width must equal the register width");
	end
	if (CODES_P != 2 * HALF_W_P || CODES_P != (1 << CODE_W)) begin : g_bad_codes
		$error("code count must fill both halves and the code field");
	end

	// Enable-set writes: ones set, zeros leave the bit alone
	always_comb begin
		enable_set = '0;
		if (ENA_SET_LO_WR_I) begin
			enable_set[REG_W-1:0] = WR_DATA_I;
		end
		if (ENA_SET_HI_WR_I) begin
			enable_set[NUM_CODES-1:REG_W] = WR_DATA_I;
		end
	end

	// OR-only update, so a zero bit has no effect
	assign enable_nxt = enable_r | enable_set;

	// Pending-clear writes, one half per strobe
	always_comb begin
		pending_clr = '0;
		if (PEND_CLR_LO_WR_I) begin
			pending_clr[REG_W-1:0] = WR_DATA_I;
		end
		if (PEND_CLR_HI_WR_I) begin
			pending_clr[NUM_CODES-1:REG_W] = WR_DATA_I;
		end
	end

	// Early completion is produced here, filtered by the same flags
	assign early_hit  = EARLY_DONE_I && dcip_code_wanted(EARLY_OPTIONS_I, EARLY_INTERMEDIATE_I);
	assign early_code = dcip_code_of(EARLY_OPTIONS_I);

	// One-hot decode of both code sources
	always_comb begin
		link_set  = '0;
		early_set = '0;
		if (lnk.cmpl_valid) begin
			link_set[lnk.cmpl_code] = 1'b1;
		end
		if (early_hit) begin
			early_set[early_code] = 1'b1;
		end
	end

	// Both sources may land in the same cycle; neither is dropped
	assign code_set = link_set | early_set;

	// Set beats clear so a code arriving during a clear survives
	assign pending_nxt = (pending_r & ~pending_clr) | code_set;

	// Level interrupt: drops only once every enabled pending bit is gone,
	// so a further assertion needs all of them cleared first
	assign irq_nxt = |(pending_nxt & enable_nxt);

	// Enable register
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			enable_r <= {ENABLE_RESET, ENABLE_RESET};
		end else begin
			enable_r <= enable_nxt;
		end
	end

	// Pending register, set by hardware, cleared by software writes
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			pending_r <= {PENDING_RESET, PENDING_RESET};
		end else begin
			pending_r <= pending_nxt;
		end
	end

	// Interrupt output, gated per code by its enable bit
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	// Code-seen pulse, high one cycle after any code is taken
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			seen_r <= 1'b0;
		end else begin
			seen_r <= lnk.cmpl_valid | early_hit;
		end
	end

	// Most recent code; link code wins the report when both arrive,
	// the early one still sets its own pending bit
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			last_code_r <= '0;
		end else if (lnk.cmpl_valid) begin
			last_code_r <= lnk.cmpl_code;
		end else if (early_hit) begin
			last_code_r <= early_code;
		end
	end

	// Read-back views; pending halves are written only through the clear strobes
	assign ENABLE_LO_O  = enable_r[REG_W-1:0];
	assign ENABLE_HI_O  = enable_r[NUM_CODES-1:REG_W];
	assign PENDING_LO_O = pending_r[REG_W-1:0];
	assign PENDING_HI_O = pending_r[NUM_CODES-1:REG_W];
	assign IRQ_O        = irq_r;
	assign CODE_SEEN_O  = seen_r;
	assign LAST_CODE_O  = last_code_r;

endmodule : dcip_channel_end

//--- testbench/dcip_assertions.sv
module dcip_assertions (
	input wire logic        CLK_I,
	input wire logic        RST_I,
	input wire logic        cmpl_valid,
	input wire logic [5:0]  cmpl_code,
	input wire logic        DONE_I,
	input wire logic        DONE_INTERMEDIATE_I,
	input wire logic [31:0] OPTIONS_I,
	input wire logic [31:0] WR_DATA_I,
	input wire logic        ENA_SET_LO_WR_I,
	input wire logic        PEND_CLR_LO_WR_I,
	input wire logic        PEND_CLR_HI_WR_I,
	input wire logic        EARLY_DONE_I,
	input wire logic [31:0] ENABLE_LO_O,
	input wire logic [31:0] ENABLE_HI_O,
	input wire logic [31:0] PENDING_LO_O,
	input wire logic [31:0] PENDING_HI_O,
	input wire logic        IRQ_O
);
	// Both banks as one vector of 64 codes
	wire logic [63:0] pend = {PENDING_HI_O, PENDING_LO_O};
	wire logic [63:0] ena  = {ENABLE_HI_O, ENABLE_LO_O};
	wire logic        flag = DONE_INTERMEDIATE_I ? OPTIONS_I[9] : OPTIONS_I[8];
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	code_return_a: assert property (DONE_I && flag |=> cmpl_valid &&
		cmpl_code == $past(OPTIONS_I[5:0])) else $error("code not returned");
	code_refused_a: assert property (DONE_I && !flag |=> !cmpl_valid)
		else $error("unflagged code returned");
	pend_set_a: assert property (cmpl_valid |=> pend[$past(cmpl_code)])
		else $error("pending bit not set");
	pend_hold_a: assert property (!PEND_CLR_LO_WR_I && !PEND_CLR_HI_WR_I
		|=> (pend & $past(pend)) == $past(pend)) else $error("pending bit lost");
	pend_clear_a: assert property (PEND_CLR_LO_WR_I && !cmpl_valid && !EARLY_DONE_I
		|=> (PENDING_LO_O & $past(WR_DATA_I)) == 32'h0) else $error("clear failed");
	reset_zero_a: assert property (disable iff (1'b0) RST_I
		|=> pend == 64'h0 && ena == 64'h0 && !IRQ_O) else $error("reset value wrong");
	enable_set_a: assert property (ENA_SET_LO_WR_I
		|=> (ENABLE_LO_O & $past(WR_DATA_I)) == $past(WR_DATA_I)) else $error("enable not set");
	irq_level_a: assert property (IRQ_O == |(pend & ena))
		else $error("interrupt level wrong");
endmodule : dcip_assertions

//--- testbench/dma_completion_irq_pending_tb.sv
module dma_completion_irq_pending_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, rst = 1'b1, done = 1'b0, d_int = 1'b0, e_done = 1'b0, e_int = 1'b0;
	logic [31:0] channel_options_word = 32'h0, e_opt = 32'h0, wdata = 32'h0, ena_lo, ena_hi, pend_lo, pend_hi;
	logic [3:0]  wr = 4'h0;
	logic        irq, sent, seen;
	logic [5:0]  last, exp_l = 6'h0;
	logic [63:0] exp_p = 64'h0, exp_e = 64'h0;
	int          fail_count = 0, comparisons = 0;
	int          codes[4] = '{0, 31, 32, 63};
	dcip_if lnk ();
	dcip_transfer_end i_dcip_transfer_end (.CLK_I(clk), .RST_I(rst), .DONE_I(done),
		.DONE_INTERMEDIATE_I(d_int), .OPTIONS_I(channel_options_word), .CODE_SENT_O(sent), .lnk(lnk));
	dcip_channel_end i_dcip_channel_end (.CLK_I(clk), .RST_I(rst), .WR_DATA_I(wdata),
		.ENA_SET_LO_WR_I(wr[0]), .ENA_SET_HI_WR_I(wr[1]), .PEND_CLR_LO_WR_I(wr[2]),
		.PEND_CLR_HI_WR_I(wr[3]), .EARLY_DONE_I(e_done), .EARLY_INTERMEDIATE_I(e_int),
		.EARLY_OPTIONS_I(e_opt), .lnk(lnk), .ENABLE_LO_O(ena_lo), .ENABLE_HI_O(ena_hi),
		.PENDING_LO_O(pend_lo), .PENDING_HI_O(pend_hi), .IRQ_O(irq), .CODE_SEEN_O(seen),
		.LAST_CODE_O(last));
	dcip_assertions i_dcip_assertions (.CLK_I(clk), .RST_I(rst), .cmpl_valid(lnk.cmpl_valid),
		.cmpl_code(lnk.cmpl_code), .DONE_I(done), .DONE_INTERMEDIATE_I(d_int),
		.OPTIONS_I(channel_options_word), .WR_DATA_I(wdata), .ENA_SET_LO_WR_I(wr[0]), .PEND_CLR_LO_WR_I(wr[2]),
		.PEND_CLR_HI_WR_I(wr[3]), .EARLY_DONE_I(e_done), .ENABLE_LO_O(ena_lo),
		.ENABLE_HI_O(ena_hi), .PENDING_LO_O(pend_lo), .PENDING_HI_O(pend_hi), .IRQ_O(irq));
	// Free-running system clock
	initial forever #25 clk = ~clk;
	task automatic check(input string what, input logic [63:0] seen_v, input logic [63:0] exp_v);
		comparisons++;
		if (seen_v !== exp_v) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp_v, seen_v);
		end
	endtask : check
	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report
	// Pending, enable and interrupt against the bench's own model
	task automatic state();
		check("pending", {pend_hi, pend_lo}, exp_p);
		check("enable", {ena_hi, ena_lo}, exp_e);
		check("irq", irq, |(exp_p & exp_e));
	endtask : state
	// One strobe for one cycle; sel 0..3 = set lo, set hi, clear lo, clear hi
	task automatic reg_wr(input int sel, input logic [31:0] d);
		@(posedge clk);
		wr <= 4'h1 << sel;
		wdata <= d;
		@(posedge clk);
		wr <= 4'h0;
		#1;
	endtask : reg_wr
	// Completion pulse from either end; pending lands two edges after the pulse edge from the link, one from the early end
	task automatic complete(input logic early, input logic inter, input logic [31:0] o,
		input logic want);
		@(posedge clk);
		if (early) begin
			e_done <= 1'b1;
			e_int <= inter;
			e_opt <= o;
		end else begin
			done <= 1'b1;
			d_int <= inter;
			channel_options_word <= o;
		end
		@(posedge clk);
		done <= 1'b0;
		e_done <= 1'b0;
		#1 check("sent", sent, want & ~early);
		check("seen early", seen, want & early);
		@(posedge clk);
		#1;
		if (want) exp_p[o[5:0]] = 1'b1;
		if (want) exp_l = o[5:0];
		check("seen link", seen, want & ~early);
		check("last code", last, exp_l);
		state();
	endtask : complete
	// Main sequence; interrupt stays masked until the first enable write
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1 state();
		foreach (codes[i]) complete(1'b0, i[0], (i[0] ? 32'h200 : 32'h100) | codes[i], 1'b1);
		complete(1'b0, 1'b0, 32'h205, 1'b0);
		complete(1'b0, 1'b1, 32'h105, 1'b0);
		complete(1'b1, 1'b1, 32'h228, 1'b1);
		complete(1'b1, 1'b0, 32'h011, 1'b0);
		reg_wr(0, 32'h1);
		exp_e[0] = 1'b1;
		state();
		reg_wr(0, 32'h0);
		state();
		reg_wr(1, 32'h8000_0000);
		exp_e[63] = 1'b1;
		state();
		reg_wr(1, 32'h0);
		state();
		reg_wr(2, 32'hffff_ffff);
		exp_p[31:0] = 32'h0;
		state();
		repeat (5) @(posedge clk);
		#1 state();
		reg_wr(3, 32'hffff_ffff);
		exp_p[63:32] = 32'h0;
		state();
		fork
			complete(1'b1, 1'b0, 32'h105, 1'b1);
			reg_wr(2, 32'h0000_0020);
		join
		reg_wr(2, 32'h0000_0020);
		exp_p[5] = 1'b0;
		state();
		final_report();
	end
endmodule : dma_completion_irq_pending_tb
